// *** pkg/pixel_port_pkg.sv ***
// Constants, field layout and types shared by the pixel input port design
package pixel_port_pkg;

    // Data path widths
    localparam int DATA_W   = 10;
    localparam int WORD_W   = 3 * DATA_W + 4;
    localparam int ADDR_W   = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] TIMING_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_FMT_LSB   = 0;
    localparam int CTRL_OS2X_BIT  = 2;
    localparam int CTRL_ASYNC_BIT = 3;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Status register fields
    localparam int STAT_ADDR_BIT = 0;
    localparam int STAT_FILT_BIT = 1;
    localparam int STAT_OVF_BIT  = 2;
    localparam int STAT_INTP_BIT = 3;
    localparam int STAT_LAT_LSB  = 8;

    // Timing register fields
    localparam int TIM_LINE_LSB = 0;
    localparam int TIM_PIX_LSB  = 16;
    localparam int CNT_W        = 12;

    // Delay word layout, valid bit on top
    localparam int WORD_VALID = WORD_W - 1;
    localparam int WORD_BLANK = WORD_W - 2;
    localparam int WORD_LINE  = WORD_W - 3;
    localparam int WORD_FRAME = WORD_W - 4;

    // Pipeline latency in clock cycles
    localparam logic [4:0] LATENCY_BASE = 5'd16;
    localparam logic [4:0] LATENCY_OS2X = 5'd29;
    localparam int         LATENCY_MAX  = 29;

    // Pixel clock figures the source must meet, in kHz
    localparam int PIX_CLK_PS_KHZ    = 27000;
    localparam int PIX_CLK_HD_KHZ    = 74250;
    localparam int PIX_CLK_ASYNC_KHZ = 81000;

    // Reset pin low time, rounded up to whole cycles
    localparam int CLOCK_MHZ     = 40;
    localparam int RESET_LOW_NS  = 100;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLOCK_MHZ + 999) / 1000;

    // Input format encodings
    typedef enum logic [1:0] {
        FMT_YCC444 = 2'b00,
        FMT_YCC422 = 2'b01,
        FMT_RGB444 = 2'b11
    } fmt_e;

    // Chroma phase on the shared port in 4:2:2
    typedef enum logic {
        PH_CB = 1'b0,
        PH_CR = 1'b1
    } phase_e;

endpackage : pixel_port_pkg

// *** design/pixel_delay_line.sv ***
// Tapped shift register giving the selectable pipeline delay
`timescale 1ns/1ps
`default_nettype none

module pixel_delay_line #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 29
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Control
    input  wire logic             advance,
    input  wire logic [4:0]       tap_sel,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_reg [DEPTH];

    // Stage 0 takes the new word, the rest shift along
    always_ff @(posedge clock) begin
        if (rst) begin
            stage_reg[0] <= '0;
        end else if (advance) begin
            stage_reg[0] <= din;
        end
    end

    // One flip-flop bank per delay stage
    genvar gi;
    generate
        for (gi = 1; gi < DEPTH; gi++) begin : g_stage
            always_ff @(posedge clock) begin
                if (rst) begin
                    stage_reg[gi] <= '0;
                end else if (advance) begin
                    stage_reg[gi] <= stage_reg[gi-1];
                end
            end
        end
    endgenerate

    // Tap select; out-of-range taps read the last stage
    assign dout = (int'(tap_sel) < DEPTH) ? stage_reg[tap_sel] : stage_reg[DEPTH-1];

endmodule : pixel_delay_line

`default_nettype wire

// *** design/video_pixel_input_port.sv ***
// Pixel input port: pin capture, channel mapping, fixed latency and APB registers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R01) Pixel appears after 16 cycles, 29 with 2x oversampling in YCrCb formats.
// (R02) Source supplies 27, 74.25 or up to 81 MHz pixel clock per mode.
// (R03) Luma port carries Y in component mode, green in RGB mode.
// (R04) Colour port carries Cr in 4:4:4, red in RGB, ignored in 4:2:2.
// (R05) Shared chroma port carries multiplexed Cr/Cb in 4:2:2, blue in RGB.
// (R06) Active-low reset pin clears timing generator and control registers to defaults.
// (R07) Address-select pin level gives least significant variable serial address bit.
// (R08) Address-select high enables serial input noise filter, low disables it.
// (R09) Blanking input marks blanking intervals, driven alongside the pixel data.
// (R10) Line input is horizontal sync normally, composite sync in async timing mode.
// (R11) Frame input is vertical sync normally, alternate timing control in async mode.
// (R12) Luma to channel A, colour port to B, shared chroma port to C.
// (R13) Source keeps codes 64-940/64-960 for component outputs, full range RGB.
// (R14) All pixel words are captured on the rising clock edge in every format.
// (R15) 4:4:4 input bypasses the internal chroma interpolation.
// (R16) Control inputs are sampled on the same edge as their pixel data.
module video_pixel_input_port #(
    parameter int DATA_W = pixel_port_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pixel pins from the source
    input  wire logic [DATA_W-1:0] luma_port,
    input  wire logic [DATA_W-1:0] red_chroma_port,
    input  wire logic [DATA_W-1:0] mux_chroma_port,
    input  wire logic              blank_ctrl_in,
    input  wire logic              line_timing_in,
    input  wire logic              frame_timing_in,
    // Device pins
    input  wire logic              reset_n_pin,
    input  wire logic              bus_addr_select_pin,
    // Serial bus configuration
    output logic                   serial_addr_lsb,
    output logic                   serial_filter_en,
    // Converter channel stream
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic      [DATA_W-1:0] out_chan_a,
    output logic      [DATA_W-1:0] out_chan_b,
    output logic      [DATA_W-1:0] out_chan_c,
    output logic                   out_blank,
    output logic                   out_hsync,
    output logic                   out_vsync,
    output logic                   out_csync,
    output logic                   out_alt_timing,
    output logic                   out_interp_on
);

    localparam int PIN_W  = 3 * DATA_W + 5;
    localparam int WORD_W = 3 * DATA_W + 4;
    localparam int CNT_W  = pixel_port_pkg::CNT_W;

    // Pin synchronisers; the first stage feeds only the second
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic [PIN_W-1:0] pin_raw;

    assign pin_raw = {reset_n_pin, bus_addr_select_pin, blank_ctrl_in, line_timing_in,
                      frame_timing_in, luma_port, red_chroma_port, mux_chroma_port};

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg <= {1'b1, {(PIN_W-1){1'b0}}};
            pin_sync_reg <= {1'b1, {(PIN_W-1){1'b0}}};
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg; // R14 R16
        end
    end

    // Captured pin fields, all from the same edge
    wire              cap_reset_n = pin_sync_reg[PIN_W-1];
    wire              cap_addr    = pin_sync_reg[PIN_W-2];
    wire              cap_blank   = pin_sync_reg[PIN_W-3];
    wire              cap_line    = pin_sync_reg[PIN_W-4];
    wire              cap_frame   = pin_sync_reg[PIN_W-5];
    wire [DATA_W-1:0] cap_luma    = pin_sync_reg[3*DATA_W-1:2*DATA_W];
    wire [DATA_W-1:0] cap_red     = pin_sync_reg[2*DATA_W-1:DATA_W];
    wire [DATA_W-1:0] cap_mux     = pin_sync_reg[DATA_W-1:0];

    // Reset pin must stay low a minimum time, rejecting glitches
    localparam int RST_CNT_W = $clog2(pixel_port_pkg::RESET_LOW_CYC + 1);
    localparam logic [RST_CNT_W-1:0] RST_CNT_MAX =
        RST_CNT_W'(pixel_port_pkg::RESET_LOW_CYC);
    logic [RST_CNT_W-1:0] rst_low_reg;
    logic [RST_CNT_W-1:0] rst_low_next;
    wire                  pin_reset   = (rst_low_reg == RST_CNT_MAX);
    wire                  dev_reset   = rst | pin_reset; // R06

    assign rst_low_next = cap_reset_n ? '0 :
                          (pin_reset ? rst_low_reg : rst_low_reg + RST_CNT_W'(1));

    always_ff @(posedge clock) begin
        if (rst) begin
            rst_low_reg <= '0;
        end else begin
            rst_low_reg <= rst_low_next;
        end
    end

    // Address select drives serial address bit and filter enable
    logic addr_sel_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            addr_sel_reg <= 1'b0;
        end else begin
            addr_sel_reg <= cap_addr;
        end
    end

    assign serial_addr_lsb  = addr_sel_reg; // R07
    assign serial_filter_en = addr_sel_reg; // R08

    // Control register fields
    logic [4:0] ctrl_reg;
    wire  [1:0] fmt_raw    = ctrl_reg[pixel_port_pkg::CTRL_FMT_LSB +: 2];
    wire        os2x       = ctrl_reg[pixel_port_pkg::CTRL_OS2X_BIT];
    wire        async_mode = ctrl_reg[pixel_port_pkg::CTRL_ASYNC_BIT];
    wire        fmt_422    = (fmt_raw == pixel_port_pkg::FMT_YCC422);
    wire        fmt_rgb    = (fmt_raw == pixel_port_pkg::FMT_RGB444);

    // Latency; RGB stays at base latency even at 2x
    wire [4:0] latency = (os2x && !fmt_rgb) ? pixel_port_pkg::LATENCY_OS2X
                                            : pixel_port_pkg::LATENCY_BASE; // R01
    // Capture is cycle 0; the buffer register adds one after the tap
    wire [4:0] tap_sel = latency - 5'd2; // R01

    // 4:2:2 chroma demultiplex with sample-and-hold interpolation
    pixel_port_pkg::phase_e phase_reg;
    pixel_port_pkg::phase_e phase_next;
    logic [DATA_W-1:0]      cr_hold_reg;
    logic [DATA_W-1:0]      cb_hold_reg;

    // Phase restarts on Cb at every blanking interval
    assign phase_next = cap_blank ? pixel_port_pkg::PH_CB :
                        (phase_reg == pixel_port_pkg::PH_CB) ? pixel_port_pkg::PH_CR
                                                             : pixel_port_pkg::PH_CB; // R05 R09

    always_ff @(posedge clock) begin
        if (dev_reset) begin
            phase_reg   <= pixel_port_pkg::PH_CB;
            cr_hold_reg <= '0;
            cb_hold_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            if (!cap_blank && phase_reg == pixel_port_pkg::PH_CR) begin
                cr_hold_reg <= cap_mux; // R05
            end
            if (!cap_blank && phase_reg == pixel_port_pkg::PH_CB) begin
                cb_hold_reg <= cap_mux; // R05
            end
        end
    end

    // Channel routing; colour port unused in 4:2:2, bypassed path in 4:4:4
    wire [DATA_W-1:0] chan_a = cap_luma; // R03 R12
    wire [DATA_W-1:0] chan_b = fmt_422 ? cr_hold_reg : cap_red; // R04 R12 R15
    wire [DATA_W-1:0] chan_c = fmt_422 ? cb_hold_reg : cap_mux; // R05 R12 R15

    // Data and control travel together through the same delay word
    wire [WORD_W-1:0] word_in = {1'b1, cap_blank, cap_line, cap_frame,
                                 chan_a, chan_b, chan_c}; // R16
    logic [WORD_W-1:0] word_tap;
    logic              buf_in_ready;

    pixel_delay_line #(
        .WIDTH (WORD_W),
        .DEPTH (pixel_port_pkg::LATENCY_MAX)
    ) u_delay (
        .clock   (clock),
        .rst     (dev_reset),
        .advance (buf_in_ready),
        .tap_sel (tap_sel),
        .din     (word_in),
        .dout    (word_tap)
    );

    // Two-entry output buffer; a full buffer freezes the delay line
    logic [WORD_W-1:0] buf_mem_reg [2];
    logic              buf_wptr_reg;
    logic              buf_rptr_reg;
    logic [1:0]        buf_cnt_reg;
    logic [1:0]        buf_cnt_next;
    wire               buf_push = buf_in_ready && word_tap[pixel_port_pkg::WORD_VALID];
    wire               buf_pop  = out_valid && out_ready;

    assign buf_in_ready = (buf_cnt_reg != 2'd2);
    assign out_valid    = (buf_cnt_reg != 2'd0);
    assign buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};

    always_ff @(posedge clock) begin
        if (dev_reset) begin
            buf_wptr_reg <= 1'b0;
            buf_rptr_reg <= 1'b0;
            buf_cnt_reg  <= 2'd0;
        end else begin
            buf_wptr_reg <= buf_wptr_reg ^ buf_push;
            buf_rptr_reg <= buf_rptr_reg ^ buf_pop;
            buf_cnt_reg  <= buf_cnt_next;
        end
    end

    // Storage needs no reset; empty entries are never shown as valid
    always_ff @(posedge clock) begin
        if (buf_push) begin
            buf_mem_reg[buf_wptr_reg] <= word_tap;
        end
    end

    // Head entry fields
    wire [WORD_W-1:0] head = buf_mem_reg[buf_rptr_reg];

    assign out_chan_a     = head[3*DATA_W-1:2*DATA_W];
    assign out_chan_b     = head[2*DATA_W-1:DATA_W];
    assign out_chan_c     = head[DATA_W-1:0];
    assign out_blank      = out_valid && head[pixel_port_pkg::WORD_BLANK]; // R09
    // Sync roles follow the timing mode
    assign out_hsync      = out_valid && !async_mode && head[pixel_port_pkg::WORD_LINE];  // R10
    assign out_csync      = out_valid && async_mode && head[pixel_port_pkg::WORD_LINE];   // R10
    assign out_vsync      = out_valid && !async_mode && head[pixel_port_pkg::WORD_FRAME]; // R11
    assign out_alt_timing = out_valid && async_mode && head[pixel_port_pkg::WORD_FRAME];  // R11
    assign out_interp_on  = fmt_422; // R15

    // Timing generator: pixel and line counters from the sync edges
    logic             line_prev_reg;
    logic             frame_prev_reg;
    logic [CNT_W-1:0] pix_cnt_reg;
    logic [CNT_W-1:0] line_cnt_reg;
    wire              line_edge  = cap_line && !line_prev_reg;
    wire              frame_edge = cap_frame && !frame_prev_reg;

    always_ff @(posedge clock) begin
        if (dev_reset) begin
            line_prev_reg  <= 1'b0;
            frame_prev_reg <= 1'b0;
            pix_cnt_reg    <= '0;
            line_cnt_reg   <= '0;
        end else begin
            line_prev_reg  <= cap_line;
            frame_prev_reg <= cap_frame;
            pix_cnt_reg    <= line_edge ? '0 : pix_cnt_reg + CNT_W'(1); // R10
            if (frame_edge) begin
                line_cnt_reg <= '0; // R11
            end else if (line_edge) begin
                line_cnt_reg <= line_cnt_reg + CNT_W'(1); // R10
            end
        end
    end

    // Overflow: a captured word lost while the buffer stalls
    logic ovf_reg;

    // APB decode
    wire setup     = psel && !penable;
    wire access    = psel && penable;
    wire hit_ctrl  = (paddr == pixel_port_pkg::CTRL_OFS);
    wire hit_stat  = (paddr == pixel_port_pkg::STATUS_OFS);
    wire hit_time  = (paddr == pixel_port_pkg::TIMING_OFS);
    wire hit_any   = hit_ctrl || hit_stat || hit_time;
    wire wr_ctrl   = access && pwrite && hit_ctrl && pstrb[0];
    wire clr_ovf   = access && pwrite && hit_stat && pstrb[0] &&
                     pwdata[pixel_port_pkg::STAT_OVF_BIT];
    wire lost_word = !buf_in_ready && !dev_reset;

    // Control register, defaults restored by either reset
    always_ff @(posedge clock) begin
        if (dev_reset) begin
            ctrl_reg <= pixel_port_pkg::CTRL_RESET; // R06
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[4:0];
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge clock) begin
        if (dev_reset) begin
            ovf_reg <= 1'b0;
        end else if (lost_word) begin
            ovf_reg <= 1'b1;
        end else if (clr_ovf) begin
            ovf_reg <= 1'b0;
        end
    end

    // Read words
    logic [31:0] stat_word;
    logic [31:0] time_word;
    logic [31:0] rd_mux;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[pixel_port_pkg::STAT_ADDR_BIT] = addr_sel_reg;
        stat_word[pixel_port_pkg::STAT_FILT_BIT] = addr_sel_reg;
        stat_word[pixel_port_pkg::STAT_OVF_BIT]  = ovf_reg;
        stat_word[pixel_port_pkg::STAT_INTP_BIT] = fmt_422;
        stat_word[pixel_port_pkg::STAT_LAT_LSB +: 5] = latency;
        time_word = 32'h0000_0000;
        time_word[pixel_port_pkg::TIM_LINE_LSB +: CNT_W] = line_cnt_reg;
        time_word[pixel_port_pkg::TIM_PIX_LSB +: CNT_W]  = pix_cnt_reg;
    end

    assign rd_mux = hit_ctrl ? {27'h000_0000, ctrl_reg} :
                    hit_stat ? stat_word :
                    hit_time ? time_word : 32'h0000_0000;

    // Read data is latched in the setup cycle, so access needs no wait
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access && !hit_any;

endmodule : video_pixel_input_port

`default_nettype wire

// *** tb/video_pixel_input_port_props.sv ***
// Checker watching the pixel input port pins for timing and mapping slips
`timescale 1ns/1ps
`default_nettype none
module video_pixel_input_port_props #(
    parameter int DATA_W = 10
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // APB slave
    input wire logic [7:0]        paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Pixel pins
    input wire logic [DATA_W-1:0] luma_port,
    input wire logic [DATA_W-1:0] red_chroma_port,
    input wire logic [DATA_W-1:0] mux_chroma_port,
    input wire logic              blank_ctrl_in,
    input wire logic              line_timing_in,
    input wire logic              frame_timing_in,
    // Device pins and serial configuration
    input wire logic              reset_n_pin,
    input wire logic              bus_addr_select_pin,
    input wire logic              serial_addr_lsb,
    input wire logic              serial_filter_en,
    // Converter channel stream
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire logic [DATA_W-1:0] out_chan_a,
    input wire logic [DATA_W-1:0] out_chan_b,
    input wire logic [DATA_W-1:0] out_chan_c,
    input wire logic              out_blank,
    input wire logic              out_hsync,
    input wire logic              out_vsync,
    input wire logic              out_csync,
    input wire logic              out_alt_timing,
    input wire logic              out_interp_on
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Pin levels need the synchroniser plus the register stage to settle
    sequence s_sel_hi; bus_addr_select_pin [*4]; endsequence
    sequence s_sel_lo; !bus_addr_select_pin [*4]; endsequence
    sequence s_pin_low; !reset_n_pin [*8]; endsequence
    property p_addr_hi; s_sel_hi |-> serial_addr_lsb; endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("address bit stuck low");
    property p_filt_lo; s_sel_lo |-> !serial_filter_en; endproperty
    a_filt_lo: assert property (p_filt_lo) else $error("filter on with pin low");
    property p_filt_eq; serial_filter_en == serial_addr_lsb; endproperty
    a_filt_eq: assert property (p_filt_eq) else $error("filter and address differ");
    // A long device reset empties the stream and restores the default format
    property p_pin_flush; s_pin_low |=> !out_valid; endproperty
    a_pin_flush: assert property (p_pin_flush) else $error("stream kept in reset");
    property p_pin_cfg; s_pin_low |=> !out_interp_on; endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("format kept in reset");
    property p_csync; out_csync |-> !out_hsync && !out_vsync; endproperty
    a_csync: assert property (p_csync) else $error("line input in two roles");
    property p_alt; out_alt_timing |-> !out_hsync && !out_vsync; endproperty
    a_alt: assert property (p_alt) else $error("frame input in two roles");
    property p_gate;
        !out_valid |-> !(out_blank || out_hsync || out_vsync || out_csync || out_alt_timing);
    endproperty
    a_gate: assert property (p_gate) else $error("control without word");
    // A stalled head word must keep its three channels until taken
    property p_hold;
        out_valid && !out_ready && reset_n_pin |=>
            out_valid && $stable(out_chan_a) && $stable(out_chan_b) && $stable(out_chan_c);
    endproperty
    a_hold: assert property (p_hold) else $error("head word changed in stall");
endmodule : video_pixel_input_port_props
bind video_pixel_input_port video_pixel_input_port_props #(.DATA_W(DATA_W)) props_i (.*);
`default_nettype wire

// *** tb/pixel_source_model.sv ***
// Behavioural video source driving the pixel pins from a running count
`timescale 1ns/1ps
`default_nettype none
module pixel_source_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Running count the pins follow
    output logic     [15:0] seq,
    // Pixel pins
    output logic     [9:0]  luma_port,
    output logic     [9:0]  red_chroma_port,
    output logic     [9:0]  mux_chroma_port,
    output logic            blank_ctrl_in,
    output logic            line_timing_in,
    output logic            frame_timing_in
);
    // One word per clock, launched just after the edge
    always_ff @(posedge clock) begin
        if (rst) begin
            seq <= 16'h0000;
        end else begin
            seq <= seq + 16'h0001;
        end
    end
    // Codes stay in 64..767, legal for every output standard
    assign luma_port       = 10'(seq[8:0]) + 10'd64;
    assign red_chroma_port = 10'(seq[8:0]) + 10'd128;
    assign mux_chroma_port = 10'(seq[8:0]) + 10'd256;
    // Controls travel with their own data word
    assign blank_ctrl_in   = seq[5:0] < 6'd6;
    assign line_timing_in  = seq[5:0] < 6'd3;
    assign frame_timing_in = seq[6];
endmodule : pixel_source_model
`default_nettype wire

// *** tb/test_video_pixel_input_port.sv ***
// Self-checking bench for the pixel input port
`timescale 1ns/1ps
`default_nettype none
module test_video_pixel_input_port;
    // Rows: control value beside the latency it should give
    typedef struct packed { logic [3:0] ctrl; logic [4:0] lat; } row_s;
    localparam row_s ROWS [7] = '{'{4'h0, 5'd16}, '{4'h4, 5'd29}, '{4'h1, 5'd16},
        '{4'h5, 5'd29}, '{4'h3, 5'd16}, '{4'h7, 5'd16}, '{4'h8, 5'd16}};
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic        out_ready = 1'b1;
    logic        reset_n_pin = 1'b1;
    logic        bus_addr_select_pin = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, serial_addr_lsb, serial_filter_en, out_valid, out_blank, err;
    logic        out_hsync, out_vsync, out_csync, out_alt_timing, out_interp_on, asy;
    logic        blank_ctrl_in, line_timing_in, frame_timing_in;
    logic [9:0]  luma_port, red_chroma_port, mux_chroma_port, out_chan_a, out_chan_b, out_chan_c;
    logic [9:0]  m0;
    logic [15:0] seq, s;
    int          off, fail_count = 0, num_checks = 0;
    video_pixel_input_port video_pixel_input_port_i (.*);
    pixel_source_model pixel_source_model_i (.*);
    always #12.5 clock = ~clock;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits until the word now at the outputs has the given count phase
    task automatic wait_phase(input logic [5:0] t);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            s = seq - 16'(off);
            n++;
        end while (s[5:0] != t && n < 80);
        if (s[5:0] != t) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_phase
    initial begin
        repeat (20) @(posedge clock);
        #1;
        check("valid_in_rst", out_valid, 0);
        @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, pixel_port_pkg::CTRL_OFS, 32'h0);
        check("ctrl_reset", rd, 0);
        // Row loop: format, oversampling and timing mode against latency and mapping
        foreach (ROWS[i]) begin
            apb(1'b1, pixel_port_pkg::CTRL_OFS, {28'h000_0000, ROWS[i].ctrl});
            off = int'(ROWS[i].lat) + 2;
            asy = ROWS[i].ctrl[3];
            repeat (40) @(posedge clock);
            for (int k = 0; k < 2; k++) begin
                wait_phase(k ? 6'd20 : 6'd2);
                m0 = 10'(s[8:0]) + 10'd256;
                check("chan_a", out_chan_a, 10'(s[8:0]) + 10'd64);
                check("ctrl_out", {out_valid, out_blank, out_hsync, out_vsync, out_csync,
                    out_alt_timing}, {1'b1, s[5:0] < 6'd6, !asy && s[5:0] < 6'd3, !asy && s[6],
                    asy && s[5:0] < 6'd3, asy && s[6]});
                if (ROWS[i].ctrl[1:0] != 2'b01)
                    check("chan_bc", {out_chan_b, out_chan_c}, {m0 - 10'd128, m0});
                else if (k == 1)
                    check("pair", {out_chan_b, out_chan_c}, {m0 - 10'd1, m0 - 10'd2});
            end
            check("interp", out_interp_on, ROWS[i].ctrl[1:0] == 2'b01);
            apb(1'b0, pixel_port_pkg::STATUS_OFS, 32'h0);
            check("latency", rd[12:8], ROWS[i].lat);
        end
        // Unmapped address is refused
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 0);
        check("slverr", err, 1);
        // Stall the consumer past the buffer depth, then clear the sticky loss flag
        out_ready <= 1'b0;
        repeat (12) @(posedge clock);
        apb(1'b0, pixel_port_pkg::STATUS_OFS, 32'h0);
        check("ovf_set", rd[2], 1);
        out_ready <= 1'b1;
        apb(1'b1, pixel_port_pkg::STATUS_OFS, 32'h0000_0004);
        apb(1'b0, pixel_port_pkg::STATUS_OFS, 32'h0);
        check("ovf_clr", rd[2], 0);
        // Address select pin both ways
        for (int v = 1; v >= 0; v--) begin
            bus_addr_select_pin <= 1'(v);
            repeat (5) @(posedge clock);
            #1;
            check("addr_lsb", serial_addr_lsb, v);
            check("filter", serial_filter_en, v);
        end
        // Short reset pulse is ignored, a long one restores defaults
        apb(1'b1, pixel_port_pkg::CTRL_OFS, 32'h0000_0005);
        for (int w = 2; w <= 10; w += 8) begin
            @(posedge clock);
            reset_n_pin <= 1'b0;
            repeat (w) @(posedge clock);
            reset_n_pin <= 1'b1;
            repeat (10) @(posedge clock);
            apb(1'b0, pixel_port_pkg::CTRL_OFS, 32'h0);
            check("ctrl_pin", rd, (w == 2) ? 5 : 0);
        end
        report_and_stop();
    end
endmodule : test_video_pixel_input_port
`default_nettype wire
